// [rtl/wpt_pkg.sv]
// wpt_pkg: constants and types for the protocol timing block
// Notes on behaviour
// - a core-clock divider makes the 1 us tick for most protocol timings
// - a second 1 us divider drives sync timer and beacon timers, always running
// - both divider terminal counts programmable, defaults 39 and 31
// - 64-bit sync timer advances once per microsecond
// - access point never loads its sync timer from received beacons
// - infrastructure station loads sync timer from every error-free beacon
// - ad hoc station loads only when received timestamp is later
// - transmitted beacon timestamp is sync timer plus tx latency, default 58
// - received timestamp is adjusted by rx latency, default 29, before loading
// - sync timer readable as low and high 32-bit registers
// - channel busy is physical busy or virtual busy or sequence in progress
// - error-free frame other than ps-poll for others with larger duration loads the vector
// - vector counts down per microsecond and blocks transmission while nonzero
// - missing ACK or CTS within time-out records a reception error
// - ACK and CTS time-outs counted on core ticks, set by time-out register
// - RTS enable sends RTS with descriptor duration, then waits for CTS
// - error-free CTS starts data one SIFS later
// - CTS time-out reports back-off and retransmission
// - failed data after good exchange restarts with a fresh RTS/CTS
// - software alert, then DMA alert, then beacon scheduled at target time
// - no valid beacon at target time means hold until valid
// - ad hoc beacon contends with back-off, cancelled by any error-free beacon
// - writing a nonzero beacon interval enables all beacon timers together, slow domain
// - next-beacon timer in 1024 us units, 16 bits, advances one interval
package wpt_pkg;
   localparam logic [7:0] CORE_DIV_RST = 8'h27;
   localparam logic [7:0] SLOW_DIV_RST = 8'h1f;
   localparam logic [7:0] TX_LAT_RST = 8'h3a;
   localparam logic [7:0] RX_LAT_RST = 8'h1d;
   localparam logic [15:0] ACK_TO_RST = 16'h0030;
   localparam logic [15:0] CTS_TO_RST = 16'h0030;
   localparam logic [7:0] REG_USEC = 8'h00;
   localparam logic [7:0] REG_LAT = 8'h04;
   localparam logic [7:0] REG_TSF_LO = 8'h08;
   localparam logic [7:0] REG_TSF_HI = 8'h0c;
   localparam logic [7:0] REG_NAV = 8'h10;
   localparam logic [7:0] REG_TIMEOUT = 8'h14;
   localparam logic [7:0] REG_BINTV = 8'h18;
   localparam logic [7:0] REG_NEXT_TBTT = 8'h1c;
   localparam logic [7:0] REG_SBA = 8'h20;
   localparam logic [7:0] REG_DBA = 8'h24;
   localparam logic [7:0] REG_CTRL = 8'h28;
   localparam logic [7:0] REG_STATUS = 8'h2c;
   localparam int unsigned SIFS_US = 16;
   localparam int unsigned SLOT_US = 9;
   localparam int unsigned CLK_MHZ = 10;
   localparam int unsigned US_PER_128 = 128;
   localparam logic [7:0] LFSR_SEED = 8'h5a;
   typedef enum logic [1:0] {ROLE_STA, ROLE_IBSS, ROLE_AP} wpt_role_t;
   typedef enum logic [1:0] {FR_RTS, FR_DATA, FR_BEACON} wpt_kind_t;
   typedef struct packed {
      logic fcs_ok;
      logic to_me;
      logic ps_poll;
      logic beacon;
      logic cts;
      logic ack;
      logic [15:0] duration;
      logic [63:0] timestamp;
   } wpt_rx_t;
   typedef struct packed {
      logic rts_en;
      logic [15:0] rts_duration;
      logic expect_ack;
   } wpt_desc_t;
   typedef struct packed {
      wpt_kind_t kind;
      logic [15:0] duration;
      logic [63:0] timestamp;
   } wpt_frame_t;
   typedef struct packed {
      logic ok;
      logic backoff;
      logic rx_err;
   } wpt_result_t;
endpackage : wpt_pkg

// [rtl/wpt_timing.sv]
// wpt_timing: time bases, sync timer, virtual carrier sense, RTS/CTS and beacon scheduling
`timescale 1ns/10ps
module wpt_timing (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic phy_busy_i,
   input wire logic rx_valid_i,
   input wire wpt_pkg::wpt_rx_t rx_info_i,
   input wire logic tx_req_valid_i,
   input wire wpt_pkg::wpt_desc_t tx_req_i,
   output logic tx_req_ready_o,
   output logic tx_frame_valid_o,
   output wpt_pkg::wpt_frame_t tx_frame_o,
   input wire logic tx_end_i,
   output logic tx_result_valid_o,
   output wpt_pkg::wpt_result_t tx_result_o,
   input wire logic beacon_valid_i,
   output logic channel_busy_o,
   output logic sw_alert_o,
   output logic dma_alert_o,
   output logic tbtt_o
);
   import wpt_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_RTS, S_CTS_WAIT, S_SIFS, S_DATA, S_ACK_WAIT, S_BCN_BO, S_BCN}
      wpt_state_t;

   localparam logic [15:0] SIFS_CNT = 16'(SIFS_US);
   localparam logic [3:0] SLOT_CNT = 4'(SLOT_US);

   logic [7:0] core_div_q, slow_div_q, tx_lat_q, rx_lat_q;
   logic [7:0] core_cnt_q, slow_cnt_q;
   logic core_tick, slow_tick;
   logic [15:0] ack_to_q, cts_to_q;
   wpt_role_t role_q;
   logic [63:0] tsf_q;
   logic [63:0] rx_ts_adj;
   logic [31:0] tsf_hi_snap_q;
   logic [15:0] nav_q;
   logic [15:0] bintv_q, next_tbtt_q;
   logic [18:0] sba_q;
   logic [24:0] dba_q;
   logic bcn_en_q;
   logic [6:0] sub128_q;
   logic [24:0] t128_q;
   logic tick128, ev_tbtt, ev_sba, ev_dba;
   logic bcn_pend_q;
   wpt_state_t state_q;
   logic [15:0] tmr_q;
   logic [7:0] lfsr_q;
   logic [15:0] err_cnt_q;
   logic rx_good, rx_beacon, rx_cts, rx_ack;
   logic ph_wr_q;
   logic [7:0] ph_addr_q;
   logic wr_en;
   logic addr_ok;

   // bus: zero wait state, every access answered OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ok = hsel && hready && htrans[1];
   assign wr_en = ph_wr_q;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ph_wr_q <= 1'b0;
         ph_addr_q <= 8'h00;
      end else begin
         ph_wr_q <= addr_ok && hwrite;
         ph_addr_q <= haddr[7:0];
      end
   end

   // read data captured in the address phase so it stands through the data phase
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         hrdata <= 32'h0000_0000;
         tsf_hi_snap_q <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         case ({haddr[7:2], 2'b00})
            REG_USEC: hrdata <= {16'h0000, slow_div_q, core_div_q};
            REG_LAT: hrdata <= {16'h0000, rx_lat_q, tx_lat_q};
            REG_TSF_LO: begin
               hrdata <= tsf_q[31:0];
               tsf_hi_snap_q <= tsf_q[63:32];
            end
            REG_TSF_HI: hrdata <= tsf_hi_snap_q;
            REG_NAV: hrdata <= {16'h0000, nav_q};
            REG_TIMEOUT: hrdata <= {cts_to_q, ack_to_q};
            REG_BINTV: hrdata <= {15'h0000, bcn_en_q, bintv_q};
            REG_NEXT_TBTT: hrdata <= {16'h0000, next_tbtt_q};
            REG_SBA: hrdata <= {13'h0000, sba_q};
            REG_DBA: hrdata <= {7'h00, dba_q};
            REG_CTRL: hrdata <= {30'h0000_0000, role_q};
            REG_STATUS: hrdata <= {err_cnt_q, 11'h000, bcn_pend_q, 1'b0, state_q};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // software-written configuration
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         core_div_q <= CORE_DIV_RST;
         slow_div_q <= SLOW_DIV_RST;
         tx_lat_q <= TX_LAT_RST;
         rx_lat_q <= RX_LAT_RST;
         ack_to_q <= ACK_TO_RST;
         cts_to_q <= CTS_TO_RST;
         role_q <= ROLE_STA;
      end else if (wr_en) begin
         case (ph_addr_q)
            REG_USEC: begin
               core_div_q <= hwdata[7:0];
               slow_div_q <= hwdata[15:8];
            end
            REG_LAT: begin
               tx_lat_q <= hwdata[7:0];
               rx_lat_q <= hwdata[15:8];
            end
            REG_TIMEOUT: begin
               ack_to_q <= hwdata[15:0];
               cts_to_q <= hwdata[31:16];
            end
            REG_CTRL: role_q <= (hwdata[1:0] == 2'd3) ? ROLE_AP : wpt_role_t'(hwdata[1:0]);
            default: ;
         endcase
      end
   end

   // microsecond dividers; a divider changed below the current count wraps at once
   assign core_tick = (core_cnt_q >= core_div_q);
   assign slow_tick = (slow_cnt_q >= slow_div_q);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         core_cnt_q <= 8'h00;
         slow_cnt_q <= 8'h00;
      end else begin
         core_cnt_q <= core_tick ? 8'h00 : core_cnt_q + 8'h01;
         slow_cnt_q <= slow_tick ? 8'h00 : slow_cnt_q + 8'h01;
      end
   end

   // sync timer
   assign rx_good = rx_valid_i && rx_info_i.fcs_ok;
   assign rx_beacon = rx_good && rx_info_i.beacon;
   assign rx_cts = rx_good && rx_info_i.cts;
   assign rx_ack = rx_good && rx_info_i.ack;
   assign rx_ts_adj = rx_info_i.timestamp + {56'h0, rx_lat_q};

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         tsf_q <= 64'h0;
      end else if (rx_beacon && role_q == ROLE_STA) begin
         tsf_q <= rx_ts_adj;
      end else if (rx_beacon && role_q == ROLE_IBSS && rx_ts_adj > tsf_q) begin
         tsf_q <= rx_ts_adj;
      end else if (slow_tick) begin
         tsf_q <= tsf_q + 64'h1;
      end
   end

   // virtual carrier sense; ps-poll carries no duration
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         nav_q <= 16'h0000;
      end else if (rx_good && !rx_info_i.to_me && !rx_info_i.ps_poll && rx_info_i.duration > nav_q) begin
         nav_q <= rx_info_i.duration;
      end else if (core_tick && nav_q != 16'h0000) begin
         nav_q <= nav_q - 16'h0001;
      end
   end

   assign channel_busy_o = phy_busy_i || (nav_q != 16'h0000) || (state_q != S_IDLE);

   // beacon timers, all started together by a beacon interval write
   assign tick128 = slow_tick && (sub128_q == 7'(US_PER_128 - 1));
   assign ev_tbtt = tick128 && bcn_en_q && (t128_q[2:0] == 3'h0) && (t128_q[18:3] == next_tbtt_q);
   assign ev_sba = tick128 && bcn_en_q && (t128_q[18:0] == sba_q);
   assign ev_dba = tick128 && bcn_en_q && (t128_q == dba_q);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         bcn_en_q <= 1'b0;
         bintv_q <= 16'h0000;
         sub128_q <= 7'h00;
         t128_q <= 25'h0;
      end else if (wr_en && ph_addr_q == REG_BINTV) begin
         bintv_q <= hwdata[15:0];
         bcn_en_q <= hwdata[15:0] != 16'h0000;
         sub128_q <= 7'h00;
         t128_q <= 25'h0;
      end else if (slow_tick) begin
         sub128_q <= tick128 ? 7'h00 : sub128_q + 7'h01;
         if (tick128) begin
            t128_q <= t128_q + 25'h1;
         end
      end
   end

   // event times step one interval at each event; software may rewrite them
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         next_tbtt_q <= 16'h0000;
         sba_q <= 19'h0;
         dba_q <= 25'h0;
      end else begin
         if (wr_en && ph_addr_q == REG_NEXT_TBTT) begin
            next_tbtt_q <= hwdata[15:0];
         end else if (ev_tbtt) begin
            next_tbtt_q <= next_tbtt_q + bintv_q;
         end
         if (wr_en && ph_addr_q == REG_SBA) begin
            sba_q <= hwdata[18:0];
         end else if (ev_sba) begin
            sba_q <= sba_q + {bintv_q, 3'h0};
         end
         if (wr_en && ph_addr_q == REG_DBA) begin
            dba_q <= hwdata[24:0];
         end else if (ev_dba) begin
            dba_q <= dba_q + {6'h00, bintv_q, 3'h0};
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sw_alert_o <= 1'b0;
         dma_alert_o <= 1'b0;
         tbtt_o <= 1'b0;
      end else begin
         sw_alert_o <= ev_sba;
         dma_alert_o <= ev_dba;
         tbtt_o <= ev_tbtt;
      end
   end

   // a pending beacon survives until sent or cancelled; a new tbtt wins over a clear
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         bcn_pend_q <= 1'b0;
      end else if (ev_tbtt && role_q != ROLE_STA) begin
         bcn_pend_q <= 1'b1;
      end else if (state_q == S_BCN && tx_end_i) begin
         bcn_pend_q <= 1'b0;
      end else if (rx_beacon && role_q == ROLE_IBSS) begin
         bcn_pend_q <= 1'b0;
      end
   end

   // pseudo-random slot draw for ad hoc beacon contention, window 0..31 slots
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         lfsr_q <= LFSR_SEED;
      end else begin
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      end
   end

   // frame sequencer
   assign tx_req_ready_o = (state_q == S_IDLE) && !bcn_pend_q && nav_q == 16'h0000;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_q <= S_IDLE;
         tmr_q <= 16'h0000;
         tx_frame_valid_o <= 1'b0;
         tx_frame_o <= '0;
         tx_result_valid_o <= 1'b0;
         tx_result_o <= '0;
         err_cnt_q <= 16'h0000;
      end else begin
         tx_frame_valid_o <= 1'b0;
         tx_result_valid_o <= 1'b0;
         if (core_tick && tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
         end
         case (state_q)
            S_IDLE: begin
               if (bcn_pend_q && beacon_valid_i && nav_q == 16'h0000) begin
                  if (role_q == ROLE_IBSS) begin
                     tmr_q <= {11'h000, lfsr_q[4:0]} * {12'h000, SLOT_CNT};
                     state_q <= S_BCN_BO;
                  end else begin
                     tx_frame_valid_o <= 1'b1;
                     tx_frame_o <= '{FR_BEACON, 16'h0000, tsf_q + {56'h0, tx_lat_q}};
                     state_q <= S_BCN;
                  end
               end else if (tx_req_valid_i && tx_req_ready_o) begin
                  tx_frame_valid_o <= 1'b1;
                  // every new request with rts enabled opens a fresh exchange
                  if (tx_req_i.rts_en) begin
                     tx_frame_o <= '{FR_RTS, tx_req_i.rts_duration, 64'h0};
                     state_q <= S_RTS;
                  end else begin
                     tx_frame_o <= '{FR_DATA, 16'h0000, 64'h0};
                     state_q <= S_DATA;
                  end
                  tx_result_o.backoff <= tx_req_i.expect_ack;
               end
            end
            S_RTS: begin
               if (tx_end_i) begin
                  tmr_q <= cts_to_q;
                  state_q <= S_CTS_WAIT;
               end
            end
            S_CTS_WAIT: begin
               if (rx_cts) begin
                  tmr_q <= SIFS_CNT;
                  state_q <= S_SIFS;
               end else if (tmr_q == 16'h0000) begin
                  tx_result_valid_o <= 1'b1;
                  tx_result_o <= '{1'b0, 1'b1, 1'b1};
                  err_cnt_q <= err_cnt_q + 16'h0001;
                  state_q <= S_IDLE;
               end
            end
            S_SIFS: begin
               if (tmr_q == 16'h0000) begin
                  tx_frame_valid_o <= 1'b1;
                  tx_frame_o <= '{FR_DATA, 16'h0000, 64'h0};
                  state_q <= S_DATA;
               end
            end
            S_DATA: begin
               if (tx_end_i) begin
                  // backoff bit held the expect-ack flag since the request
                  if (tx_result_o.backoff) begin
                     tmr_q <= ack_to_q;
                     state_q <= S_ACK_WAIT;
                  end else begin
                     tx_result_valid_o <= 1'b1;
                     tx_result_o <= '{1'b1, 1'b0, 1'b0};
                     state_q <= S_IDLE;
                  end
               end
            end
            S_ACK_WAIT: begin
               if (rx_ack) begin
                  tx_result_valid_o <= 1'b1;
                  tx_result_o <= '{1'b1, 1'b0, 1'b0};
                  state_q <= S_IDLE;
               end else if (tmr_q == 16'h0000) begin
                  tx_result_valid_o <= 1'b1;
                  tx_result_o <= '{1'b0, 1'b1, 1'b1};
                  err_cnt_q <= err_cnt_q + 16'h0001;
                  state_q <= S_IDLE;
               end
            end
            S_BCN_BO: begin
               if (rx_beacon) begin
                  state_q <= S_IDLE;
               end else if (tmr_q == 16'h0000 && !phy_busy_i && nav_q == 16'h0000) begin
                  tx_frame_valid_o <= 1'b1;
                  tx_frame_o <= '{FR_BEACON, 16'h0000, tsf_q + {56'h0, tx_lat_q}};
                  state_q <= S_BCN;
               end
            end
            S_BCN: begin
               if (tx_end_i) begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule : wpt_timing

// [tb/wpt_baseband_model.sv]
// model: baseband that sends frames on air and returns cts and ack
`timescale 1ns/10ps
module wpt_baseband_model (
   input wire logic sys_clk_i,
   input wire logic frame_valid_i,
   input wire wpt_pkg::wpt_frame_t frame_i,
   input wire logic [1:0] mode_i,
   input wire logic [7:0] air_i,
   output logic tx_end_o,
   output logic rx_valid_o,
   output wpt_pkg::wpt_rx_t rx_info_o
);
   import wpt_pkg::*;
   initial begin
      tx_end_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_info_o = '0;
   end
   // fields inverted after the pulse so stale data never passes
   task automatic send(input wpt_rx_t r);
      rx_valid_o <= 1'b1;
      rx_info_o <= r;
      @(posedge sys_clk_i);
      rx_valid_o <= 1'b0;
      rx_info_o <= ~r;
   endtask : send
   // mode 0 answers all, 1 drops cts and ack, 2 and 3 drop ack
   task automatic reply(input wpt_kind_t k);
      repeat (air_i) @(posedge sys_clk_i);
      tx_end_o <= 1'b1;
      @(posedge sys_clk_i);
      tx_end_o <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      if (k == FR_RTS && mode_i != 2'd1) begin
         send(wpt_rx_t'({6'b110010, 16'h0, 64'h0}));
      end else if (k == FR_DATA && mode_i == 2'd0) begin
         send(wpt_rx_t'({6'b110001, 16'h0, 64'h0}));
      end
   endtask : reply
   always @(negedge sys_clk_i) begin
      if (frame_valid_i === 1'b1) begin
         reply(frame_i.kind);
      end
   end
endmodule : wpt_baseband_model

// [tb/wpt_timing_properties.sv]
// checker: port-level properties of the protocol timing block
`timescale 1ns/10ps
module wpt_timing_properties (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic phy_busy_i,
   input wire logic rx_valid_i,
   input wire wpt_pkg::wpt_rx_t rx_info_i,
   input wire logic tx_req_valid_i,
   input wire wpt_pkg::wpt_desc_t tx_req_i,
   input wire logic tx_req_ready_o,
   input wire logic tx_frame_valid_o,
   input wire wpt_pkg::wpt_frame_t tx_frame_o,
   input wire logic tx_result_valid_o,
   input wire wpt_pkg::wpt_result_t tx_result_o,
   input wire logic channel_busy_o,
   input wire logic tbtt_o
);
   import wpt_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_phy; phy_busy_i |-> channel_busy_o; endproperty
   a_phy: assert property (p_phy) else $error("busy low under medium busy");
   property p_take; tx_req_valid_i && tx_req_ready_o |=> tx_frame_valid_o; endproperty
   a_take: assert property (p_take) else $error("no frame after take");
   property p_rts;
      tx_req_valid_i && tx_req_ready_o && tx_req_i.rts_en |=>
         tx_frame_o.kind == FR_RTS && tx_frame_o.duration == $past(tx_req_i.rts_duration);
   endproperty
   a_rts: assert property (p_rts) else $error("rts frame wrong");
   property p_nav;
      rx_valid_i && rx_info_i.fcs_ok && !rx_info_i.to_me && !rx_info_i.ps_poll && rx_info_i.duration > 16'd2
         |=> (channel_busy_o && !tx_req_ready_o) [*2];
   endproperty
   a_nav: assert property (p_nav) else $error("vector did not block");
   property p_seq; tx_frame_valid_o |-> channel_busy_o && !tx_req_ready_o; endproperty
   a_seq: assert property (p_seq) else $error("idle during sequence");
   // sifs is at least 16 us, so never under 8 cycles whatever the divider
   property p_sifs; rx_valid_i && rx_info_i.cts && rx_info_i.fcs_ok |=> !tx_frame_valid_o [*8]; endproperty
   a_sifs: assert property (p_sifs) else $error("data before sifs");
   property p_err;
      tx_result_valid_o && tx_result_o.rx_err |-> tx_result_o.backoff && !tx_result_o.ok;
   endproperty
   a_err: assert property (p_err) else $error("timeout result wrong");
   property p_res; tx_result_valid_o |=> !tx_result_valid_o; endproperty
   a_res: assert property (p_res) else $error("result pulse long");
   property p_tbtt; tbtt_o |=> !tbtt_o [*4]; endproperty
   a_tbtt: assert property (p_tbtt) else $error("tbtt repeated");
   property p_bus; hreadyout && !hresp; endproperty
   a_bus: assert property (p_bus) else $error("bus not okay");
endmodule : wpt_timing_properties
bind wpt_timing wpt_timing_properties wpt_timing_properties_inst (.sys_clk_i, .sys_rst_i, .hreadyout, .hresp,
   .phy_busy_i, .rx_valid_i, .rx_info_i, .tx_req_valid_i, .tx_req_i, .tx_req_ready_o, .tx_frame_valid_o,
   .tx_frame_o, .tx_result_valid_o, .tx_result_o, .channel_busy_o, .tbtt_o);

// [tb/wpt_timing_tb.sv]
// testbench: bus, receive, transmit and beacon sequences for the timing block
`timescale 1ns/10ps
module wpt_timing_tb;
   import wpt_pkg::*;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic phy_busy_i = 1'b0;
   logic tx_req_valid_i = 1'b0;
   logic beacon_valid_i = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'b010;
   logic [1:0] mode = '0;
   logic [7:0] air = 8'd2;
   wpt_desc_t tx_req_i = '0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, tx_req_ready_o, tx_frame_valid_o, tx_end_i, tx_result_valid_o, rx_valid_i;
   logic channel_busy_o, sw_alert_o, dma_alert_o, tbtt_o;
   wpt_rx_t rx_info_i;
   wpt_frame_t tx_frame_o;
   wpt_result_t tx_result_o;
   logic [7:0] kinds = '0;
   logic [15:0] rts_dur = '0;
   int miscompares = 0;
   int checks_done = 0;
   logic [31:0] d, a, b;
   logic hit;
   wire logic [4:0] ev = {tbtt_o, dma_alert_o, sw_alert_o, tx_frame_valid_o, tx_result_valid_o};
   always #50 sys_clk_i = ~sys_clk_i;
   wpt_timing wpt_timing_inst (.sys_clk_i, .sys_rst_i, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .phy_busy_i, .rx_valid_i, .rx_info_i, .tx_req_valid_i,
      .tx_req_i, .tx_req_ready_o, .tx_frame_valid_o, .tx_frame_o, .tx_end_i, .tx_result_valid_o, .tx_result_o,
      .beacon_valid_i, .channel_busy_o, .sw_alert_o, .dma_alert_o, .tbtt_o);
   wpt_baseband_model wpt_baseband_model_inst (.sys_clk_i, .frame_valid_i(tx_frame_valid_o),
      .frame_i(tx_frame_o), .mode_i(mode), .air_i(air), .tx_end_o(tx_end_i), .rx_valid_o(rx_valid_i),
      .rx_info_o(rx_info_i));
   always @(negedge sys_clk_i) begin
      if (tx_frame_valid_o === 1'b1) begin
         kinds <= {kinds[5:0], tx_frame_o.kind};
         if (tx_frame_o.kind == FR_RTS) begin
            rts_dur <= tx_frame_o.duration;
         end
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic wen, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wen;
      haddr <= {24'h0, adr};
      do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] adr, input logic [31:0] v);
      logic [31:0] t;
      ahb(1'b1, adr, v, t);
   endtask : wr
   task automatic rr(input logic [7:0] adr, output logic [31:0] v);
      ahb(1'b0, adr, 32'h0, v);
   endtask : rr
   task automatic rx(input logic [5:0] f, input logic [15:0] dur, input logic [63:0] ts);
      wpt_baseband_model_inst.send(wpt_rx_t'({f, dur, ts}));
      @(posedge sys_clk_i);
   endtask : rx
   // pulses are looked at mid-cycle, then the bench realigns to the rising edge
   task automatic wait_bit(input int bi, input int lim, output logic h);
      h = 1'b0;
      for (int i = 0; i < lim && !h; i++) begin
         @(negedge sys_clk_i);
         h = ev[bi];
      end
      @(posedge sys_clk_i);
   endtask : wait_bit
   task automatic sync(input logic [1:0] role, input logic [31:0] hi, input logic [31:0] exp);
      wr(REG_CTRL, {30'h0, role});
      rx(6'b100100, 16'h0, {hi, 32'h100});
      rr(REG_TSF_LO, a);
      rr(REG_TSF_HI, b);
      chk(b, exp);
   endtask : sync
   task automatic tx_run(input logic [17:0] dsc, input logic [2:0] exp);
      int n;
      tx_req_valid_i <= 1'b1;
      tx_req_i <= wpt_desc_t'(dsc);
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (tx_req_ready_o !== 1'b1 && n < 200);
      @(posedge sys_clk_i);
      tx_req_valid_i <= 1'b0;
      wait_bit(0, 3000, hit);
      chk({hit, tx_result_o}, {1'b1, exp});
   endtask : tx_run
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (30000) @(posedge sys_clk_i);
      miscompares++;
      wrap_up;
   end
   initial begin
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      rr(REG_USEC, d); chk(d, 32'h1f27);
      rr(REG_LAT, d); chk(d, 32'h1d3a);
      rr(REG_TIMEOUT, d); chk(d, 32'h0030_0030);
      rr(8'h30, d); chk(d, 32'h0);
      // both dividers at 1: one microsecond is two cycles, keeping the run short
      wr(REG_USEC, 32'h0101);
      rr(REG_TSF_LO, a);
      repeat (20) @(posedge sys_clk_i);
      rr(REG_TSF_LO, b); chk(b - a >= 10 && b - a <= 12, 1);
      sync(2'd0, 32'h5, 32'h5); chk(a - 32'h11d <= 8, 1);
      sync(2'd2, 32'h9, 32'h5);
      sync(2'd1, 32'h3, 32'h5);
      sync(2'd1, 32'h7, 32'h7);
      rx(6'b100000, 16'd40, 64'h0);
      rr(REG_NAV, d); chk(d >= 37 && d <= 40, 1);
      @(negedge sys_clk_i); chk({channel_busy_o, tx_req_ready_o}, 2'b10);
      @(posedge sys_clk_i);
      rx(6'b110000, 16'd200, 64'h0);
      rx(6'b101000, 16'd300, 64'h0);
      rx(6'b000000, 16'd500, 64'h0);
      rr(REG_NAV, d); chk(d <= 40, 1);
      phy_busy_i <= 1'b1;
      repeat (100) @(posedge sys_clk_i);
      phy_busy_i <= 1'b0;
      rr(REG_NAV, d); chk(d, 0);
      @(negedge sys_clk_i); chk(channel_busy_o, 0);
      @(posedge sys_clk_i);
      wr(REG_TIMEOUT, 32'h0014_0014);
      tx_run({1'b1, 16'h1234, 1'b1}, 3'b100); chk({kinds[3:0], rts_dur}, {4'b0001, 16'h1234});
      mode <= 2'd1;
      air <= 8'd30;
      tx_run({1'b1, 16'h1234, 1'b1}, 3'b011); chk(kinds[1:0], FR_RTS);
      mode <= 2'd2;
      tx_run({1'b1, 16'h1234, 1'b1}, 3'b011);
      mode <= 2'd0;
      tx_run({1'b1, 16'h1234, 1'b1}, 3'b100); chk(kinds, 8'b0001_0001);
      rr(REG_STATUS, d); chk(d[31:16], 16'd2);
      tx_run({1'b0, 16'h0, 1'b0}, 3'b100); chk(kinds[1:0], FR_DATA);
      wr(REG_SBA, 32'd4);
      wr(REG_DBA, 32'd6);
      wr(REG_NEXT_TBTT, 32'd1);
      wr(REG_CTRL, 32'd2);
      wr(REG_BINTV, 32'd2);
      rr(REG_BINTV, d); chk(d, 32'h0001_0002);
      wait_bit(2, 3000, hit); chk(hit, 1);
      wait_bit(3, 1000, hit); chk(hit, 1);
      wait_bit(4, 1000, hit); chk(hit, 1);
      rr(REG_NEXT_TBTT, d); chk(d, 32'd3);
      wait_bit(1, 200, hit); chk(hit, 0);
      beacon_valid_i <= 1'b1;
      wait_bit(1, 50, hit); chk({hit, tx_frame_o.kind}, {1'b1, FR_BEACON});
      beacon_valid_i <= 1'b0;
      rr(REG_TSF_LO, d); chk(d - (tx_frame_o.timestamp[31:0] - 32'd58) <= 12, 1);
      wr(REG_CTRL, 32'd1);
      wait_bit(2, 5000, hit); chk(hit, 1);
      beacon_valid_i <= 1'b1;
      wait_bit(4, 1100, hit); chk(hit, 1);
      rx(6'b100100, 16'h0, 64'h0);
      wait_bit(1, 700, hit); chk(hit, 0);
      wrap_up;
   end
endmodule : wpt_timing_tb
